/* File: tb/i2c_master_transaction_engine_chk.sv */
// Port-level assertions for the transaction engine
`timescale 1ns/1ps
module i2c_master_transaction_engine_chk (
   input wire logic       ref_clk,
   input wire logic       link_clk,
   input wire logic       rstn,
   input wire logic       transaction_launch_register,
   input wire logic       status_read,
   input wire logic [1:0] transaction_result,
   input wire logic       launch_rejected_flag,
   input wire logic       address_nack_flag,
   input wire logic       data_nack_flag,
   input wire logic       transaction_busy,
   input wire logic       scl_oe,
   input wire logic       sda_oe
);
   property p_accept;
      @(posedge ref_clk) disable iff (!rstn)
      transaction_launch_register && !transaction_busy |=> transaction_busy && transaction_result == 2'h1;
   endproperty
   a_accept: assert property (p_accept) else $error("launch not accepted");
   property p_reject;
      @(posedge ref_clk) disable iff (!rstn)
      transaction_launch_register && transaction_busy |=> launch_rejected_flag && transaction_busy;
   endproperty
   a_reject: assert property (p_reject) else $error("busy launch not flagged");
   property p_busy_res;
      @(posedge ref_clk) disable iff (!rstn) transaction_busy |-> transaction_result == 2'h1;
   endproperty
   a_busy_res: assert property (p_busy_res) else $error("result not in progress");
   property p_idle_free;
      @(posedge ref_clk) disable iff (!rstn) !transaction_busy |-> !scl_oe && !sda_oe;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("bus driven while idle");
   property p_scl_low;
      @(posedge link_clk) disable iff (!rstn) $rose(scl_oe) |-> scl_oe [*4];
   endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock low phase short");
   property p_err_flag;
      @(posedge ref_clk) disable iff (!rstn)
      $fell(transaction_busy) && transaction_result == 2'h2 |-> address_nack_flag || data_nack_flag;
   endproperty
   a_err_flag: assert property (p_err_flag) else $error("error without nack");
   property p_end_res;
      @(posedge ref_clk) disable iff (!rstn) $fell(transaction_busy) |-> transaction_result[1];
   endproperty
   a_end_res: assert property (p_end_res) else $error("no final result");
   property p_clear;
      @(posedge ref_clk) disable iff (!rstn)
      status_read && !transaction_launch_register |=> !launch_rejected_flag;
   endproperty
   a_clear: assert property (p_clear) else $error("reject flag not cleared");
endmodule : i2c_master_transaction_engine_chk
bind i2c_master_transaction_engine i2c_master_transaction_engine_chk u_chk (
   .ref_clk(ref_clk), .link_clk(link_clk), .rstn(rstn), .status_read(status_read),
   .transaction_launch_register(transaction_launch_register), .transaction_result(transaction_result),
   .launch_rejected_flag(launch_rejected_flag), .address_nack_flag(address_nack_flag),
   .data_nack_flag(data_nack_flag), .transaction_busy(transaction_busy), .scl_oe(scl_oe), .sda_oe(sda_oe));

/* File: tb/i2c_slave_model.sv */
// Behavioural bus slave: acks writes, logs bytes, returns a counting pattern
`timescale 1ns/1ps
module i2c_slave_model (
   input  wire logic scl,  // Bus clock line
   input  wire logic sda,  // Bus data line
   input  wire logic nack, // Absent slave, never acks
   output logic      pull  // Pulls the data line low
);
   logic [7:0] log_q [$]; // Bytes the master wrote
   logic [7:0] sh;        // Shift register
   logic [7:0] tx;        // Next byte to return
   int         n;         // Clock edges in this byte
   bit         go;        // Read address seen
   bit         rd;        // Returning data
   bit         first;     // Next byte is an address
   initial begin
      pull = 0; n = 0; go = 0; rd = 0; first = 0;
   end
   // Start or repeated start restarts framing
   always @(negedge sda) if (scl === 1'b1) begin
      n = 0; first = 1; go = 0; rd = 0;
   end
   // Stop ends any read phase
   always @(posedge sda) if (scl === 1'b1) begin
      rd = 0; go = 0; pull = 0;
   end
   // Sample on rising clock
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      n++;
   end
   // Change the line only while the clock is low
   always @(negedge scl) begin
      if (n == 8 && !rd) begin
         log_q.push_back(sh);
         pull = !nack;
         go = first && sh[0];
         first = 0;
      end else if (n == 9) begin
         n = 0;
         pull = 0;
         if (go) begin
            rd = 1; go = 0; tx = 8'h5A;
         end else if (rd) begin
            // Master NACK frees the line for its stop
            if (sh[0]) rd = 0;
            else tx++;
         end
      end
      if (rd) pull = (n < 8) ? !tx[7-n] : 1'b0;
   end
endmodule : i2c_slave_model

/* File: tb/tb_i2c_master_transaction_engine.sv */
// Self-checking bench: engine against the slave model on a pulled-up bus
`timescale 1ns/1ps
module tb_i2c_master_transaction_engine;
   import i2c_txn_pkg::*;
   logic ref_clk = 0, link_clk = 0, rstn = 0, launch = 0, dir = 0, ten = 0;
   logic fmt = 0, plen = 0, zdw = 0, stat = 0, nack = 0;
   logic [1:0]  dlen = 0;
   logic [9:0]  addr = 0;
   logic [15:0] ptr = 0;
   byte_t       wd [4] = '{8'h11, 8'h22, 8'h33, 8'h44}; // Write data
   byte_t       rd [4];                                 // Read data seen
   result_t     res;
   logic        rej, anack, dnack, busy, scl_oe, sda_oe, pull;
   wire         scl = ~scl_oe;          // Pull-up on clock
   wire         sda = ~(sda_oe | pull); // Pull-up on data, wired low
   int          num_errors = 0, checks_done = 0;
   always #5 ref_clk = ~ref_clk;
   // Link clock period 32 ns, phase unrelated
   always #16 link_clk = ~link_clk;
   i2c_master_transaction_engine #(.QUARTER_CYCLES(2)) u_i2c_master_transaction_engine (
      .ref_clk(ref_clk), .link_clk(link_clk), .rstn(rstn), .transaction_launch_register(launch),
      .direction_select(dir), .ten_bit_address_select(ten), .read_format_select(fmt),
      .pointer_length_select(plen), .data_length_select(dlen), .zero_data_write(zdw),
      .slave_address(addr), .pointer_bytes(ptr), .write_data_byte_0(wd[0]), .write_data_byte_1(wd[1]),
      .write_data_byte_2(wd[2]), .write_data_byte_3(wd[3]), .status_read(stat), .transaction_result(res),
      .launch_rejected_flag(rej), .address_nack_flag(anack), .data_nack_flag(dnack), .transaction_busy(busy),
      .read_data_byte_0(rd[0]), .read_data_byte_1(rd[1]), .read_data_byte_2(rd[2]), .read_data_byte_3(rd[3]),
      .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
   i2c_slave_model u_i2c_slave_model (.scl(scl), .sda(sda), .nack(nack), .pull(pull));
   // Compare and count
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Launch one transaction, optionally a refused second launch, wait for the end
   task go(input logic d, t, f, p, z, input logic [1:0] l, input bit again);
      int k;
      u_i2c_slave_model.log_q.delete();
      @(negedge ref_clk);
      dir = d; ten = t; fmt = f; plen = p; zdw = z; dlen = l; launch = 1;
      @(negedge ref_clk);
      launch = again;
      dir = d ^ again;
      chk("busy", busy, 1);
      @(negedge ref_clk);
      launch = 0;
      dir = d;
      if (again) chk("rejected", rej, 1);
      k = 0;
      while (busy !== 1'b0 && k < 30000) begin
         @(negedge ref_clk);
         k++;
      end
      chk("finished", k < 30000, 1);
   endtask : go
   // Software status read
   task sread;
      @(negedge ref_clk);
      stat = 1;
      @(negedge ref_clk);
      stat = 0;
   endtask : sread
   task chk_log(input byte_t e[$]);
      chk("count", u_i2c_slave_model.log_q.size(), e.size());
      foreach (e[i]) chk("byte", u_i2c_slave_model.log_q[i], e[i]);
   endtask : chk_log
   // 7-bit write, two pointer bytes, four data bytes, refused relaunch
   task t_write;
      addr = 10'h052; ptr = 16'hC3A1;
      go(0, 0, 0, 1, 0, 2'h3, 1);
      chk_log('{8'hA4, 8'hC3, 8'hA1, 8'h11, 8'h22, 8'h33, 8'h44});
      chk("result", res, 2'h3);
      sread();
      chk("rejected", rej, 0);
      chk("result", res, 2'h0);
   endtask : t_write
   // 10-bit combined read of four bytes
   task t_read10;
      addr = 10'h2B7; ptr = 16'h0044;
      go(1, 1, 1, 0, 0, 2'h3, 0);
      chk_log('{8'hF4, 8'hB7, 8'h44, 8'hF5});
      foreach (rd[i]) chk("rx", rd[i], 8'h5A + i);
      chk("result", res, 2'h3);
   endtask : t_read10
   // 7-bit normal read of two bytes
   task t_norm7;
      addr = 10'h052;
      go(1, 0, 0, 0, 0, 2'h1, 0);
      chk_log('{8'hA5});
      chk("rx0", rd[0], 8'h5A);
      chk("rx1", rd[1], 8'h5B);
   endtask : t_norm7
   // Pointer-only write to an absent slave, then a retry
   task t_nack;
      nack = 1;
      go(0, 0, 0, 0, 1, 2'h0, 0);
      chk_log('{8'hA4, 8'h44});
      chk("result", res, 2'h2);
      chk("addr nack", anack, 1);
      chk("data nack", dnack, 1);
      nack = 0;
      sread();
      go(0, 0, 0, 0, 1, 2'h0, 0);
      chk("result", res, 2'h3);
      chk("addr nack", anack, 0);
      chk("data nack", dnack, 0);
   endtask : t_nack
   task results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      repeat (6) @(negedge ref_clk);
      rstn = 1;
      t_write();
      t_read10();
      t_norm7();
      t_nack();
      results();
   end
   // Hang guard, well past the expected run
   initial begin
      #500_000;
      num_errors++;
      results();
   end
endmodule : tb_i2c_master_transaction_engine

/* File: verilog/i2c_master_transaction_engine.sv */
// I2C master transaction sequencer: launch/status side on ref_clk, bus side on link_clk
// Notes on behaviour
// RULE1 - Write transaction starts on accepted launch, direction zero
// RULE2 - Master drives SCL from start to stop
// RULE3 - Master drives SDA on write bits, releases acks
// RULE4 - Order: address, then pointer, then data bytes
// RULE5 - Write data taken from write data bytes
// RULE6 - Writes framed by START and STOP
// RULE7 - Slave pulls SDA low to acknowledge
// RULE8 - Missing ack flags error, transaction still completes
// RULE9 - Software may retry with identical launch
// RULE10 - Pointer one or two bytes, data zero-four
// RULE11 - Read starts on accepted launch, direction one
// RULE12 - Combined read: START, write part, repeated START
// RULE13 - Combined read write part sends pointer bytes
// RULE14 - Drive address after Sr, then release SDA
// RULE15 - Master acks each received byte low except the last
// RULE16 - Last read byte gets NACK, then STOP
// RULE17 - Read pointer one-two bytes, data one-four
// RULE18 - Only addressed slave acks later address bytes
// RULE19 - Ten-bit select one means 10-bit addressing
// RULE20 - Read format one selects combined format
// RULE21 - Pointer length zero one byte; data one two
// RULE22 - Zero-data writes meant for setting pointer
// RULE23 - Launch while busy ignored, sets rejection flag
// RULE24 - Result codes none/busy/error/done, busy until end
// RULE25 - R/W bit one after Sr, zero before
// RULE26 - Ten-bit first byte carries 11110 prefix
`timescale 1ns/1ps
`include "i2c_txn_map.svh"
module i2c_master_transaction_engine #(
   parameter int QUARTER_CYCLES = `I2C_TXN_QUARTER_CYCLES
) (
   input  wire logic                ref_clk,
   input  wire logic                link_clk,
   input  wire logic                rstn,
   input  wire logic                transaction_launch_register,
   input  wire logic                direction_select,
   input  wire logic                ten_bit_address_select,
   input  wire logic                read_format_select,
   input  wire logic                pointer_length_select,
   input  wire logic [1:0]          data_length_select,
   input  wire logic                zero_data_write,
   input  wire logic [9:0]          slave_address,
   input  wire logic [15:0]         pointer_bytes,
   input  wire logic [7:0]          write_data_byte_0,
   input  wire logic [7:0]          write_data_byte_1,
   input  wire logic [7:0]          write_data_byte_2,
   input  wire logic [7:0]          write_data_byte_3,
   input  wire logic                status_read,
   output i2c_txn_pkg::result_t     transaction_result,
   output logic                     launch_rejected_flag,
   output logic                     address_nack_flag,
   output logic                     data_nack_flag,
   output logic                     transaction_busy,
   output i2c_txn_pkg::byte_t       read_data_byte_0,
   output i2c_txn_pkg::byte_t       read_data_byte_1,
   output i2c_txn_pkg::byte_t       read_data_byte_2,
   output i2c_txn_pkg::byte_t       read_data_byte_3,
   input  wire logic                scl_i,
   output logic                     scl_o,
   output logic                     scl_oe,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe
);
   import i2c_txn_pkg::*;
   // Ref clock side: launch shadow and events
   logic        sh_dir, sh_ten, sh_comb; // Latched direction, address mode, read format
   logic        sh_ptr_two, sh_zero; // Latched pointer length, zero-data write
   logic [1:0]  sh_len; // Latched data length
   logic [9:0]  sh_addr; // Latched slave address
   logic [15:0] sh_ptr; // Latched pointer bytes
   byte_t       sh_wdata [0:3]; // Latched write data bytes
   logic        req_tgl, accept; // Request toggle to link; launch taken
   logic [2:0]  ev_sync, ev_prev; // Synchronised link toggles and last value
   logic        done_ev, addr_nack_ev, data_nack_ev; // End, address nack, data nack
   // Link clock side
   logic [1:0]  pin_sync; // Synchronised {scl, sda}
   logic        req_sync, req_seen; // Request toggle and last one acted on
   logic        start_pulse, tick; // New transaction; quarter bit elapsed
   logic [15:0] qcnt; // Quarter bit divider
   seq_state_t  state; // Bus sequencer state
   byte_kind_t  kind; // Kind of byte on the wire
   logic [1:0]  phase; // Quarter within the bit
   logic [3:0]  bit_cnt; // Bit within byte, 8 is the ack slot
   logic        ptr_idx; // Pointer byte index
   logic [1:0]  data_idx, rx_idx; // Write and receive byte indices
   logic [7:0]  shift; // Receive shift register
   logic        ack_high, err; // Ack slot level; frame saw a missing ack
   byte_t       rdata [0:3]; // Received bytes
   logic        done_tgl, addr_nack_tgl, data_nack_tgl; // End and nack toggles
   byte_t       tx_byte; // Byte being transmitted
   logic        is_rx, rx_more; // Byte from slave; more read bytes follow
   logic        next_sda_low, next_scl_low; // Lines pulled low next cycle

   assign accept  = transaction_launch_register && !transaction_busy;
   assign done_ev      = ev_sync[0] ^ ev_prev[0];
   assign addr_nack_ev = ev_sync[1] ^ ev_prev[1];
   assign data_nack_ev = ev_sync[2] ^ ev_prev[2];

   // Link events into ref_clk
   i2c_txn_sync #(.WIDTH(3)) u_ev_sync (
      .clk      (ref_clk),
      .rstn     (rstn),
      .async_in ({data_nack_tgl, addr_nack_tgl, done_tgl}),
      .sync_out (ev_sync)
   );

   // Edge detect on the second synchroniser flop
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) ev_prev <= 3'h0;
      else       ev_prev <= ev_sync;
   end

   // Shadow copy of the launch content; frozen while busy so link logic may read it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {sh_dir, sh_ten, sh_comb, sh_ptr_two, sh_len, sh_zero} <= 7'h00;
         {sh_addr, sh_ptr} <= 26'h0000000;
         sh_wdata <= '{default: 8'h00};
      end else if (accept) begin  // RULE9
         {sh_dir, sh_ten, sh_comb, sh_ptr_two, sh_len, sh_zero} <= {direction_select, ten_bit_address_select,
            read_format_select, pointer_length_select, data_length_select, zero_data_write};
         {sh_addr, sh_ptr} <= {slave_address, pointer_bytes};
         sh_wdata <= '{write_data_byte_0, write_data_byte_1, write_data_byte_2, write_data_byte_3};  // RULE5
      end
   end

   // Busy flag and request toggle; a launch while busy never reaches the link
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         transaction_busy <= 1'b0;
         req_tgl          <= 1'b0;
      end else if (accept) begin  // RULE1 RULE11
         transaction_busy <= 1'b1;
         req_tgl          <= ~req_tgl;
      end else if (done_ev) begin
         transaction_busy <= 1'b0;
      end
   end

   // Result code; completion beats a clearing status read in the same cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         transaction_result <= `I2C_TXN_RES_NONE;
      end else if (accept) begin
         transaction_result <= `I2C_TXN_RES_BUSY;  // RULE24
      end else if (done_ev) begin
         transaction_result <= err ? `I2C_TXN_RES_ERROR : `I2C_TXN_RES_DONE;  // RULE8 RULE24
      end else if (status_read && !transaction_busy) begin
         transaction_result <= `I2C_TXN_RES_NONE;
      end
   end

   // Sticky alert flags; set wins over a clear
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         launch_rejected_flag <= 1'b0;
         address_nack_flag    <= 1'b0;
         data_nack_flag       <= 1'b0;
      end else begin
         if (transaction_launch_register && transaction_busy)
            launch_rejected_flag <= 1'b1;  // RULE23
         else if (status_read)
            launch_rejected_flag <= 1'b0;
         if (addr_nack_ev)
            address_nack_flag <= 1'b1;  // RULE8
         else if (status_read || accept)
            address_nack_flag <= 1'b0;
         if (data_nack_ev)
            data_nack_flag <= 1'b1;  // RULE8
         else if (status_read || accept)
            data_nack_flag <= 1'b0;
      end
   end

   // Read data taken over once the link has finished; stable since link is idle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {read_data_byte_3, read_data_byte_2, read_data_byte_1, read_data_byte_0} <= 32'h00000000;
      end else if (done_ev && sh_dir == `I2C_TXN_DIR_READ) begin
         {read_data_byte_3, read_data_byte_2, read_data_byte_1, read_data_byte_0} <=
            {rdata[3], rdata[2], rdata[1], rdata[0]};
      end
   end

   // Bus pins and request toggle enter the link domain
   i2c_txn_sync #(.WIDTH(2)) u_pin_sync (
      .clk      (link_clk),
      .rstn     (rstn),
      .async_in ({scl_i, sda_i}),
      .sync_out (pin_sync)
   );
   i2c_txn_sync #(.WIDTH(1)) u_req_sync (
      .clk      (link_clk),
      .rstn     (rstn),
      .async_in (req_tgl),
      .sync_out (req_sync)
   );

   assign start_pulse = req_sync ^ req_seen;
   assign tick        = (state != ST_IDLE) && (qcnt == 16'(QUARTER_CYCLES - 1));

   // Request edge tracking
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) req_seen <= 1'b0;
      else       req_seen <= req_sync;
   end

   // Quarter bit divider, held at zero while idle
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn)                          qcnt <= 16'h0000;
      else if (state == ST_IDLE || tick)  qcnt <= 16'h0000;
      else                                qcnt <= qcnt + 16'h0001;
   end

   // Byte contents on the wire
   always_comb begin
      tx_byte = 8'h00;
      unique case (kind)
         K_ADDR1W: tx_byte = sh_ten ? {`I2C_TXN_TEN_BIT_PREFIX, sh_addr[9:8], `I2C_TXN_RW_WRITE}  // RULE19 RULE26
                                    : {sh_addr[6:0], `I2C_TXN_RW_WRITE};  // RULE25
         K_ADDR2:  tx_byte = sh_addr[7:0];
         K_PTR:    tx_byte = (sh_ptr_two && !ptr_idx) ? sh_ptr[15:8] : sh_ptr[7:0];  // RULE13
         K_DATA:   tx_byte = sh_wdata[data_idx];  // RULE5
         K_ADDR1R: tx_byte = sh_ten ? {`I2C_TXN_TEN_BIT_PREFIX, sh_addr[9:8], `I2C_TXN_RW_READ}  // RULE26
                                    : {sh_addr[6:0], `I2C_TXN_RW_READ};  // RULE25
         K_RX:     tx_byte = 8'h00;
      endcase
   end

   assign is_rx   = (kind == K_RX);
   assign rx_more = (rx_idx != sh_len);  // RULE17 RULE21

   // Sequencer: START, bytes with ack slot, repeated START, STOP
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         kind  <= K_ADDR1W;
         {phase, bit_cnt, ptr_idx, data_idx, rx_idx} <= 11'h000;
         {shift, ack_high, err} <= 10'h000;
         rdata <= '{default: 8'h00};
         {done_tgl, addr_nack_tgl, data_nack_tgl} <= 3'h0;
      end else if (state == ST_IDLE) begin
         if (start_pulse) begin  // RULE1 RULE11
            state    <= ST_START;  // RULE6
            phase    <= 2'h0;
            bit_cnt  <= 4'h0;
            ptr_idx  <= 1'b0;
            data_idx <= 2'h0;
            rx_idx   <= 2'h0;
            err      <= 1'b0;
            // Plain 7-bit normal read opens straight with the read address
            kind <= (sh_dir == `I2C_TXN_DIR_READ && !sh_ten && !sh_comb) ? K_ADDR1R : K_ADDR1W;  // RULE4 RULE20
         end
      end else if (tick) begin
         phase <= phase + 2'h1;
         // Sample SDA in the middle of SCL high
         if (state == ST_BIT && phase == 2'h2) begin
            if (bit_cnt == `I2C_TXN_ACK_SLOT) ack_high <= pin_sync[0];  // RULE7 RULE18
            else                              shift    <= {shift[6:0], pin_sync[0]};
         end
         if (phase == 2'h3) begin
            unique case (state)
               ST_START, ST_RSTART: begin
                  state   <= ST_BIT;
                  bit_cnt <= 4'h0;
               end
               ST_STOP: begin
                  state    <= ST_IDLE;
                  done_tgl <= ~done_tgl;
               end
               ST_BIT: begin
                  if (bit_cnt != `I2C_TXN_ACK_SLOT) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else begin
                     bit_cnt <= 4'h0;
                     // Missing ack is recorded but the frame carries on
                     if (!is_rx && ack_high) begin  // RULE8
                        err <= 1'b1;
                        if (kind == K_ADDR1W || kind == K_ADDR2 || kind == K_ADDR1R)
                           addr_nack_tgl <= ~addr_nack_tgl;
                        else
                           data_nack_tgl <= ~data_nack_tgl;
                     end
                     unique case (kind)
                        K_ADDR1W: begin
                           if (sh_ten)
                              kind <= K_ADDR2;
                           else if (sh_dir == `I2C_TXN_DIR_WRITE || sh_comb)
                              kind <= K_PTR;  // RULE4 RULE12
                        end
                        K_ADDR2: begin
                           if (sh_dir == `I2C_TXN_DIR_WRITE || sh_comb) begin
                              kind <= K_PTR;  // RULE4
                           end else begin
                              state <= ST_RSTART;  // RULE12
                              kind  <= K_ADDR1R;
                           end
                        end
                        K_PTR: begin
                           if (sh_ptr_two && !ptr_idx) begin  // RULE10 RULE21
                              ptr_idx <= 1'b1;
                           end else if (sh_dir == `I2C_TXN_DIR_READ) begin
                              state <= ST_RSTART;  // RULE12
                              kind  <= K_ADDR1R;
                           end else if (sh_zero) begin
                              state <= ST_STOP;  // RULE10 RULE22
                           end else begin
                              kind <= K_DATA;  // RULE4
                           end
                        end
                        K_DATA: begin
                           if (data_idx == sh_len) state <= ST_STOP;  // RULE6 RULE10
                           else                    data_idx <= data_idx + 2'h1;
                        end
                        K_ADDR1R: kind <= K_RX;  // RULE14
                        K_RX: begin
                           rdata[rx_idx] <= shift;
                           if (rx_more) rx_idx <= rx_idx + 2'h1;
                           else         state  <= ST_STOP;  // RULE16
                        end
                     endcase
                  end
               end
               ST_IDLE: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Line levels for the coming cycle; open drain, so only low is driven
   always_comb begin
      next_sda_low = 1'b0;
      next_scl_low = 1'b0;
      unique case (state)
         ST_IDLE: next_scl_low = 1'b0;  // Both lines released
         ST_START: begin  // RULE6
            next_sda_low = (phase != 2'h0);
            next_scl_low = phase[1];
         end
         ST_BIT: begin
            next_scl_low = !phase[1];  // RULE2
            // SDA holds in the first low quarter so it never moves with an SCL edge
            if (phase == 2'h0)
               next_sda_low = sda_oe;
            else if (bit_cnt == `I2C_TXN_ACK_SLOT)
               next_sda_low = is_rx && rx_more;  // RULE3 RULE15 RULE16
            else
               next_sda_low = !is_rx && !tx_byte[3'(7 - bit_cnt)];  // RULE3 RULE14
         end
         ST_RSTART: begin  // RULE12
            next_sda_low = (phase == 2'h0) ? sda_oe : (phase == 2'h3);
            next_scl_low = !phase[1];
         end
         ST_STOP: begin  // RULE6 RULE16
            next_sda_low = (phase == 2'h0) ? sda_oe : (phase != 2'h3);
            next_scl_low = !phase[1];
         end
      endcase
   end

   // Registered pin drivers
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
      end else begin
         sda_oe <= next_sda_low;
         scl_oe <= next_scl_low;  // RULE2
      end
   end

   assign sda_o = 1'b0;
   assign scl_o = 1'b0;
endmodule : i2c_master_transaction_engine

/* File: verilog/i2c_txn_map.svh */
// Constants for the transaction engine: codes, address layout and bus timing
`ifndef I2C_TXN_MAP_SVH
`define I2C_TXN_MAP_SVH

// Direction select codes
`define I2C_TXN_DIR_WRITE      1'b0
`define I2C_TXN_DIR_READ       1'b1

// Transaction result codes
`define I2C_TXN_RES_NONE       2'h0
`define I2C_TXN_RES_BUSY       2'h1
`define I2C_TXN_RES_ERROR      2'h2
`define I2C_TXN_RES_DONE       2'h3

// Address byte layout
`define I2C_TXN_TEN_BIT_PREFIX 5'h1E
`define I2C_TXN_RW_WRITE       1'b0
`define I2C_TXN_RW_READ        1'b1
`define I2C_TXN_ACK_SLOT       4'h8

// Bus timing: SCL period and link clock period in ns
`define I2C_TXN_SCL_PERIOD_NS  2500
`define I2C_TXN_LINK_PERIOD_NS 32
// Quarter bit time in link clocks, rounded up so no phase is ever short
`define I2C_TXN_QUARTER_CYCLES ((`I2C_TXN_SCL_PERIOD_NS / 4 + `I2C_TXN_LINK_PERIOD_NS - 1) / `I2C_TXN_LINK_PERIOD_NS)

`endif

/* File: verilog/i2c_txn_pkg.sv */
// Types shared by the transaction engine files
package i2c_txn_pkg;
   typedef logic [1:0] result_t;
   typedef logic [7:0] byte_t;
   typedef enum {ST_IDLE, ST_START, ST_BIT, ST_RSTART, ST_STOP} seq_state_t;
   typedef enum {K_ADDR1W, K_ADDR2, K_PTR, K_DATA, K_ADDR1R, K_RX} byte_kind_t;
endpackage : i2c_txn_pkg

/* File: verilog/i2c_txn_sync.sv */
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module i2c_txn_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;   // Metastable stage, read only by stage two

   // Two flops per lane
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : i2c_txn_sync
